// ---- inc/ics_params.svh ----
// Constants for the instruction cycle sequencer
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH
`define ICS_PHASES       4
`define ICS_INSTR_W      12
`define ICS_PC_W         10
`define ICS_DADDR_W      5
`define ICS_DATA_W       8
`define ICS_PC_RESET     10'h000
`define ICS_NOP_WORD     12'h000
`define ICS_PHASE_ONE    2'h0
`define ICS_PHASE_TWO    2'h1
`define ICS_PHASE_THREE  2'h2
`define ICS_PHASE_FOUR   2'h3
`define ICS_PHASE_OH_RESET 4'h1
`endif

// ---- inc/ics_pkg.sv ----
// Types for the instruction cycle sequencer
`default_nettype none
`include "ics_params.svh"
package ics_pkg;
	typedef logic [`ICS_INSTR_W-1:0] ics_word_t;
	typedef logic [`ICS_PC_W-1:0]    ics_pc_t;
	typedef enum {ICS_RUN, ICS_FLUSH} ics_state_t;
	typedef struct packed {
		logic phase_one;
		logic phase_two;
		logic phase_three;
		logic phase_four;
	} ics_phase_t;
	typedef struct packed {
		logic                     rd_en;
		logic                     wr_en;
	} ics_dmem_t;
	typedef struct packed {
		logic    load;
		ics_pc_t target;
	} ics_branch_t;
endpackage
`default_nettype wire

// ---- core/ics_sequencer.sv ----
// Four-phase instruction cycle sequencer with two-stage pipeline
`default_nettype none
`include "ics_params.svh"
// Summary of operation
// - The input clock is divided by four into four non-overlapping phases.
// - The program counter increments once per cycle, in phase one.
// - The program word is latched into the instruction register at phase four.
// - The latched instruction is decoded and executed in phases two to four.
// - Data memory is read in phase two and written in phase four.
// - Fetch of the next word overlaps execution of the current one.
// - An instruction that loads the program counter takes two cycles.
// - Each fetch delivers one whole 12-bit word within one cycle.
module ics_sequencer (
	input  wire logic                clock_i,
	input  wire logic                rst_n_i,
	input  wire ics_pkg::ics_word_t  prog_word_i,
	input  wire ics_pkg::ics_branch_t branch_i,
	output ics_pkg::ics_pc_t         program_counter_o,
	output ics_pkg::ics_word_t       instruction_register_o,
	output ics_pkg::ics_phase_t      phase_o,
	output ics_pkg::ics_dmem_t       dmem_o,
	output logic                     exec_valid_o,
	output logic                     decode_en_o,
	output logic                     cycle_start_o
);
	import ics_pkg::*;

	logic [1:0] phase_r;
	logic [1:0] phase_nxt;
	ics_pc_t    pc_r;
	ics_word_t  ir_r;
	ics_state_t state_r;
	logic       valid_r;
	logic       redirect;
	ics_phase_t ph;
	ics_phase_t ph_nxt;
	wire logic  tap_one;
	wire logic  tap_two;
	wire logic  tap_three;
	wire logic  tap_four;
	wire logic  tap_nxt_one;
	wire logic  tap_nxt_two;
	wire logic  tap_nxt_three;
	wire logic  tap_nxt_four;

	// Counter wraps four to one, so phases can never overlap
	assign phase_nxt = phase_r + 2'h1;

	// Redirect only counts for a live instruction in its last phase
	assign redirect = ph.phase_four && branch_i.load && valid_r;

	// Same decoder for every phase keeps the strobes identical in timing
	ics_phase_tap #(
		.CODE (`ICS_PHASE_ONE)
	) u_tap_one (
		.phase_i (phase_r),
		.hit_o   (tap_one)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_TWO)
	) u_tap_two (
		.phase_i (phase_r),
		.hit_o   (tap_two)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_THREE)
	) u_tap_three (
		.phase_i (phase_r),
		.hit_o   (tap_three)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_FOUR)
	) u_tap_four (
		.phase_i (phase_r),
		.hit_o   (tap_four)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_ONE)
	) u_tap_nxt_one (
		.phase_i (phase_nxt),
		.hit_o   (tap_nxt_one)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_TWO)
	) u_tap_nxt_two (
		.phase_i (phase_nxt),
		.hit_o   (tap_nxt_two)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_THREE)
	) u_tap_nxt_three (
		.phase_i (phase_nxt),
		.hit_o   (tap_nxt_three)
	);

	ics_phase_tap #(
		.CODE (`ICS_PHASE_FOUR)
	) u_tap_nxt_four (
		.phase_i (phase_nxt),
		.hit_o   (tap_nxt_four)
	);

	// Divide by four; phases are one-hot enables, never overlapping
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			phase_r <= `ICS_PHASE_FOUR;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	always_comb begin
		ph.phase_one       = tap_one;
		ph.phase_two       = tap_two;
		ph.phase_three     = tap_three;
		ph.phase_four      = tap_four;
		ph_nxt.phase_one   = tap_nxt_one;
		ph_nxt.phase_two   = tap_nxt_two;
		ph_nxt.phase_three = tap_nxt_three;
		ph_nxt.phase_four  = tap_nxt_four;
	end

	// Program counter: increment in phase one, branch target at phase four
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pc_r <= `ICS_PC_RESET;
		end else if (redirect) begin
			// One below target, so the phase-one step fetches the target
			pc_r <= branch_i.target - ics_pc_t'(1);
		end else if (ph.phase_one) begin
			pc_r <= pc_r + ics_pc_t'(1);
		end
	end

	// Whole word captured in one go; flushed word becomes a no-op
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ir_r <= `ICS_NOP_WORD;
		end else if (ph.phase_four) begin
			if (redirect) begin
				ir_r <= `ICS_NOP_WORD;
			end else begin
				ir_r <= prog_word_i;
			end
		end
	end

	// Extra cycle after a redirect; the reset cycle counts as one
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r <= ICS_FLUSH;
		end else if (ph.phase_four) begin
			unique case (state_r)
				ICS_RUN: begin
					if (redirect) begin
						state_r <= ICS_FLUSH;
					end
				end
				ICS_FLUSH: begin
					state_r <= ICS_RUN;
				end
			endcase
		end
	end

	// Slot is live unless its word was discarded by a redirect
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			valid_r <= 1'b0;
		end else if (ph.phase_four) begin
			unique case (state_r)
				ICS_RUN: begin
					valid_r <= !redirect;
				end
				ICS_FLUSH: begin
					valid_r <= 1'b1;
				end
			endcase
		end
	end

	// Phase outputs registered one edge early, from the next-phase decode, so they align with phases
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			// Parked in phase four with the counter, so no false step
			phase_o <= ics_phase_t'(`ICS_PHASE_OH_RESET);
		end else begin
			phase_o <= ph_nxt;
		end
	end

	always_comb begin
		program_counter_o      = pc_r;
		instruction_register_o = ir_r;
		exec_valid_o           = valid_r;
		cycle_start_o          = ph.phase_one;
		// Decode/execute window spans phases two to four
		decode_en_o   = valid_r && !ph.phase_one;
		dmem_o.rd_en  = valid_r && ph.phase_two;
		dmem_o.wr_en  = valid_r && ph.phase_four;
	end
endmodule // ics_sequencer

// Matches one phase code of the divider
module ics_phase_tap #(
	parameter logic [1:0] CODE = `ICS_PHASE_ONE
) (
	input  wire logic [1:0] phase_i,
	output logic            hit_o
);
	assign hit_o = (phase_i == CODE);
endmodule // ics_phase_tap
`default_nettype wire

// ---- test/ics_sequencer_checker.sv ----
// Port checker of the cycle sequencer
`default_nettype none
module ics_chk import ics_pkg::*; (input wire logic clock_i, rst_n_i,
	input wire ics_word_t instruction_register_o,
	input wire ics_branch_t branch_i, input wire ics_pc_t program_counter_o,
	input wire ics_phase_t phase_o, input wire ics_dmem_t dmem_o,
	input wire logic exec_valid_o, decode_en_o, cycle_start_o);
	timeunit 1ns; timeprecision 100ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [3:0] q = phase_o;
	wire logic v = exec_valid_o, f = q[0] && v;
	wire ics_pc_t pc = program_counter_o;
	wire ics_word_t ir = instruction_register_o;
	property p_rt; q[3] |=> q[2] ##1 q[1] ##1 q[0]; endproperty
	a_rt: assert property (p_rt) else $error("order");
	property p_pc; cycle_start_o |=> pc == $past(pc) + 1'b1; endproperty
	a_pc: assert property (p_pc) else $error("pc step");
	property p_hd; q[2] |=> $stable(pc); endproperty
	a_hd: assert property (p_hd) else $error("pc moved");
	property p_rd; dmem_o.rd_en == (q[2] && v); endproperty
	a_rd: assert property (p_rd) else $error("read slot");
	property p_wr; dmem_o.wr_en == f; endproperty
	a_wr: assert property (p_wr) else $error("write slot");
	property p_de; decode_en_o == (f || v && (q[2] || q[1])); endproperty
	a_de: assert property (p_de) else $error("decode");
	property p_ir; !q[0] |=> $stable(ir); endproperty
	a_ir: assert property (p_ir) else $error("ir moved");
	property p_br; f && branch_i.load |=> !v && ir == '0 &&
		pc == $past(branch_i.target) - 1'b1; endproperty
	a_br: assert property (p_br) else $error("no flush");
	c_br: cover property (f && branch_i.load);
	c_ft: cover property (f && !branch_i.load);
	c_wr: cover property (dmem_o.wr_en);
endmodule // ics_chk
bind ics_sequencer ics_chk u_chk (
	.clock_i                (clock_i),
	.rst_n_i                (rst_n_i),
	.instruction_register_o (instruction_register_o),
	.branch_i               (branch_i),
	.program_counter_o      (program_counter_o),
	.phase_o                (phase_o),
	.dmem_o                 (dmem_o),
	.exec_valid_o           (exec_valid_o),
	.decode_en_o            (decode_en_o),
	.cycle_start_o          (cycle_start_o)
);
`default_nettype wire

// ---- test/ics_pmem.sv ----
// Program memory model for the sequencer bench
`default_nettype none
module ics_pmem import ics_pkg::*; (input wire ics_pc_t addr_i,
	output var ics_word_t word_o);
	timeunit 1ns; timeprecision 100ps;
	// Word tied to its address, so a stale fetch shows
	assign word_o = {~addr_i[1:0], addr_i};
endmodule // ics_pmem
`default_nettype wire

// ---- test/instruction_cycle_sequencer_test.sv ----
// Bench of the cycle sequencer
`default_nettype none
module instruction_cycle_sequencer_test import ics_pkg::*;;
	timeunit 1ns; timeprecision 100ps;
	logic clock_i = 0, rst_n_i = 0, v, ld;
	ics_branch_t br = '0; ics_word_t wd, ir; ics_pc_t pc; ics_phase_t ph;
	int fail_count = 0, checked = 0, ep = 1, ei, ev = 1;
	initial forever #12.5 clock_i = ~clock_i;
	ics_pmem mem (.addr_i(pc), .word_o(wd));
	ics_sequencer dut (.clock_i, .rst_n_i, .prog_word_i(wd), .branch_i(br),
		.program_counter_o(pc), .instruction_register_o(ir), .phase_o(ph),
		.dmem_o(), .exec_valid_o(v), .decode_en_o(), .cycle_start_o());
	task chk(input logic [22:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask
	// Memory model ties each word to its address
	function automatic int word_at(input int a);
		return (3 - a % 4) * 1024 + a;
	endfunction
	task give_verdict;
		$display("%0d checks %0d fails", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(27));
		ei = word_at(0);
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1;
		repeat (3000) begin
			@(posedge clock_i);
			br <= {$urandom_range(3) == 0, ics_pc_t'($urandom)};
			#1;
			if (ph.phase_two)
				chk({v, pc, ir}, {ev[0], ep[9:0], ei[11:0]});
			if (ph.phase_four) begin
				// Model's own slot state decides whether a branch counts
				ld = br.load && ev[0];
				ei = ld ? 0 : word_at(ep);
				ep = ld ? br.target : (ep + 1) % 1024;
				ev = !ld;
			end
		end
		$display("pipeline test done");
		give_verdict;
	end
endmodule // instruction_cycle_sequencer_test
`default_nettype wire
